// File: lie_pkg.sv
// lie_pkg.sv: constants, field layouts and types of the link exchange state machine
package lie_pkg;

  // timing, in ns at the system clock rate
  localparam int unsigned CLK_NS        = 10;
  localparam int unsigned T_RESET_NS    = 6400;
  localparam int unsigned T_WAIT_NS     = 12800;
  localparam int unsigned T_DISC_NS     = 850;
  // least times round up, the disconnect limit rounds down
  localparam int unsigned RESET_CYC_DEF = (T_RESET_NS + CLK_NS - 1) / CLK_NS;
  localparam int unsigned WAIT_CYC_DEF  = (T_WAIT_NS + CLK_NS - 1) / CLK_NS;
  localparam int unsigned DISC_CYC_DEF  = T_DISC_NS / CLK_NS;
  localparam int unsigned TX_DIV_DEF    = 16;
  localparam int unsigned CRED_STEP     = 8;
  localparam int unsigned CRED_MAX_DEF  = 56;
  localparam int unsigned TMR_W         = 16;

  // character level
  localparam logic [6:0] NULL_PAT  = 7'h74;
  localparam logic [1:0] CC_FCT    = 2'h0;
  localparam logic [1:0] CC_EOP    = 2'h1;
  localparam logic [1:0] CC_EEP    = 2'h2;
  localparam logic [1:0] CC_ESC    = 2'h3;
  localparam logic [3:0] NEED_CTL  = 4'h2;
  localparam logic [3:0] NEED_DATA = 4'h8;
  localparam logic [3:0] LEN_CTL   = 4'h4;
  localparam logic [3:0] LEN_DATA  = 4'ha;
  localparam logic [3:0] LEN_NULL  = 4'h8;
  localparam logic [1:0] PH_PAR    = 2'h0;
  localparam logic [1:0] PH_FLAG   = 2'h1;
  localparam logic [1:0] PH_DATA   = 2'h2;

  // register map, byte addresses
  localparam int unsigned ADDR_W   = 8;
  localparam logic [7:0] A_CTRL    = 8'h00;
  localparam logic [7:0] A_STAT    = 8'h04;
  localparam logic [7:0] A_ERR     = 8'h08;
  localparam logic [7:0] A_CRED    = 8'h0c;
  localparam int unsigned CTRL_W   = 4;
  localparam int unsigned STAT_NULL = 8;
  localparam int unsigned CRED_TX_LSB = 8;
  localparam int unsigned N_ERR    = 6;
  localparam int unsigned E_DISC   = 0;
  localparam int unsigned E_PAR    = 1;
  localparam int unsigned E_ESC    = 2;
  localparam int unsigned E_SEQ    = 3;
  localparam int unsigned E_CRED   = 4;
  localparam int unsigned E_EMPTY  = 5;

  // control register, bit 0 upward: start, auto-connect, disable, soft reset
  typedef struct packed {
    logic srst;
    logic dis;
    logic auto_c;
    logic start;
  } lie_ctrl_t;

  // one received character's events
  typedef struct packed {
    logic fct;
    logic nchar;
    logic mark;
    logic par_err;
    logic esc_err;
  } lie_rx_ev_t;

  // a character ready for the serializer, first bit in bits[0]
  typedef struct packed {
    logic [3:0]  len;
    logic        par;
    logic [11:0] bits;
  } lie_txch_t;

  typedef enum logic [5:0] {
    hold_reset_state  = 6'h01,
    settle_wait_state = 6'h02,
    ready_state       = 6'h04,
    null_tx_state     = 6'h08,
    handshake_state   = 6'h10,
    operational_state = 6'h20
  } lie_state_t;

  // parity bit, flag and payload of one character; par covers the payload for the next one
  function automatic lie_txch_t lie_char(input logic prev_par, input logic is_ctl, input logic [7:0] val);
    lie_txch_t c;
    c         = '0;
    c.bits[0] = ~(prev_par ^ is_ctl);
    c.bits[1] = is_ctl;
    if (is_ctl) begin
      c.bits[2] = val[1];
      c.bits[3] = val[0];
      c.len     = LEN_CTL;
      c.par     = val[1] ^ val[0];
    end else begin
      c.bits[9:2] = val;
      c.len       = LEN_DATA;
      c.par       = ^val;
    end
    return c;
  endfunction : lie_char

endpackage : lie_pkg

// File: lie_link_fsm.sv
// lie_link_fsm.sv: exchange-level link state machine with receiver, transmitter and AHB-Lite registers
// Notes on behaviour
// - power-on, hardware or soft reset forces hold-reset
// - timeouts counted from entry into current state
// - ready advances to NULL-transmit only when enable guard true
// - NULL search on when receiver on; earlier bits ignored
// - NULL seen on bit pattern 1110100
// - ESC parity bit of first NULL not matched; next parity checked
// - FCT valid only in handshake or operational
// - normal character outside operational is an error
// - receiver fault is disconnect, parity or escape
// - disconnect after 850 ns without line edge
// - disconnect armed after hold-reset and first edge
// - parity checked only after first NULL
// - ESC not followed by FCT is escape error
// - early FCT before NULL sent is sequence error
// - credit error beyond eight per sent FCT
// - marker right after marker is empty packet
// - guard: not disable and (start or auto and NULL)
// - start and auto-connect ignored while disabled
// - transmitter stops, clears strobe, then data
// - hold-reset lasts 6.4 us, then settle-wait
// - settle-wait: receiver on, transmitter off, 12.8 us
// - NULL-transmit: send NULLs, await NULL, 12.8 us
// - handshake: send FCTs, await FCT, 12.8 us
// - operational ends on disable or any error
// - non-NULL char in settle-wait or ready resets
`timescale 1ns/1ns
module lie_link_fsm #(
  parameter int unsigned RESET_CYC = lie_pkg::RESET_CYC_DEF,
  parameter int unsigned WAIT_CYC  = lie_pkg::WAIT_CYC_DEF,
  parameter int unsigned DISC_CYC  = lie_pkg::DISC_CYC_DEF,
  parameter int unsigned TX_DIV    = lie_pkg::TX_DIV_DEF,
  parameter int unsigned CRED_MAX  = lie_pkg::CRED_MAX_DEF
) (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst,
  // ahb-lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic [31:0]      hrdata,
  output logic             hresp,
  // link pins
  input  wire logic        data_in,
  input  wire logic        strobe_in,
  output logic             data_out,
  output logic             strobe_out,
  // host character ports, bit 8 marks an end marker (bit 0: 0 normal end, 1 error end)
  input  wire logic        tx_valid,
  input  wire logic [8:0]  tx_data,
  output logic             tx_ready,
  output logic             rx_valid,
  output logic [8:0]       rx_data,
  output logic             link_run
);
  import lie_pkg::*;

  localparam int unsigned CW = $clog2(CRED_MAX + 1);
  localparam int unsigned DW = $clog2(TX_DIV);

  // refuse settings the counters cannot hold
  if (RESET_CYC < 2 || WAIT_CYC < 2 || DISC_CYC < 2 || RESET_CYC >= 2 ** TMR_W || WAIT_CYC >= 2 ** TMR_W
      || DISC_CYC >= 2 ** TMR_W || TX_DIV < 2 || CRED_MAX < CRED_STEP || CRED_MAX % CRED_STEP != 0) begin : g_chk
    $error("lie_link_fsm: unsupported parameter value");
  end

  lie_state_t       st_q, st_d;
  lie_ctrl_t        ctrl_q;
  logic             srst_q;
  logic [TMR_W-1:0] tmr_q, dcnt_q;
  logic             d_s1, d_s2, d_s3, s_s1, s_s2, s_s3;
  logic             rx_edge, rx_bit, rx_en, armed_q, disc_err;
  logic [6:0]       sr_q, sr_nx;
  logic [1:0]       ph_q, code;
  logic [3:0]       need_q;
  logic             pbit_q, flag_q, pacc_q, esc_q, null_seen_q, done;
  logic [7:0]       dat_q, dat_nx;
  lie_rx_ev_t       ev;
  logic             fault, seq_err, cred_err, empty_err, link_en, timed_out;
  logic [CW-1:0]    rx_cred_q, tx_cred_q;
  logic             last_mark_q, null_sent_q;
  logic [DW-1:0]    div_q;
  logic             tick, tx_on, fct_want, slot, tx_take;
  logic [11:0]      tsh_q, tbits;
  logic [3:0]       tcnt_q;
  logic             tpar_q;
  lie_txch_t        nx, esc_c, fct_c, dat_c;
  logic             ap, wr_q;
  logic [7:0]       ad_q;
  logic [N_ERR-1:0] err_set, err_q;

  // two flip-flops on each pin; the third stage only remembers the last settled level
  always_ff @(posedge clk) begin
    if (rst) begin
      {d_s1, d_s2, d_s3, s_s1, s_s2, s_s3} <= 6'h00;
    end else begin
      d_s1 <= data_in;
      d_s2 <= d_s1;
      d_s3 <= d_s2;
      s_s1 <= strobe_in;
      s_s2 <= s_s1;
      s_s3 <= s_s2;
    end
  end

  assign rx_edge = (d_s2 ^ d_s3) | (s_s2 ^ s_s3);
  assign rx_bit  = d_s2;
  assign rx_en   = st_q != hold_reset_state;

  // disconnect watch: silent cycles since the last edge on either line
  always_ff @(posedge clk) begin
    if (rst || !rx_en) begin
      armed_q <= 1'b0;
      dcnt_q  <= '0;
    end else begin
      if (rx_edge) armed_q <= 1'b1;
      if (rx_edge) dcnt_q <= '0;
      else if (armed_q && dcnt_q != TMR_W'(DISC_CYC)) dcnt_q <= dcnt_q + 1'b1;
    end
  end

  assign disc_err = armed_q && dcnt_q == TMR_W'(DISC_CYC);

  // character decode, combinational views of the bit just arrived
  assign sr_nx  = {sr_q[5:0], rx_bit};
  assign dat_nx = {rx_bit, dat_q[7:1]};
  assign code   = {dat_q[7], rx_bit};
  assign done   = rx_edge && null_seen_q && ph_q == PH_DATA && need_q == 4'h1;

  always_comb begin
    ev         = '0;
    ev.par_err = rx_edge && null_seen_q && ph_q == PH_FLAG && !(pacc_q ^ pbit_q ^ rx_bit);
    ev.esc_err = done && esc_q && !(flag_q && code == CC_FCT);
    ev.fct     = done && !esc_q && flag_q && code == CC_FCT;
    ev.mark    = done && !esc_q && flag_q && (code == CC_EOP || code == CC_EEP);
    ev.nchar   = ev.mark || (done && !esc_q && !flag_q);
  end

  // bit parser; nothing but the NULL search runs before the first NULL
  always_ff @(posedge clk) begin
    if (rst || !rx_en) begin
      sr_q        <= '0;
      ph_q        <= PH_PAR;
      need_q      <= '0;
      {pbit_q, flag_q, pacc_q, esc_q, null_seen_q} <= 5'h00;
      dat_q       <= '0;
    end else if (rx_edge) begin
      sr_q <= sr_nx;
      if (!null_seen_q) begin
        if (sr_nx == NULL_PAT) begin
          null_seen_q <= 1'b1;
          ph_q        <= PH_PAR;
          pacc_q      <= 1'b0;
        end
      end else begin
        unique case (ph_q)
          PH_PAR: begin
            pbit_q <= rx_bit;
            ph_q   <= PH_FLAG;
          end
          PH_FLAG: begin
            flag_q <= rx_bit;
            need_q <= rx_bit ? NEED_CTL : NEED_DATA;
            pacc_q <= 1'b0;
            ph_q   <= PH_DATA;
          end
          default: begin
            dat_q  <= dat_nx;
            pacc_q <= pacc_q ^ rx_bit;
            need_q <= need_q - 1'b1;
            if (need_q == 4'h1) begin
              ph_q <= PH_PAR;
              if (esc_q) esc_q <= 1'b0;
              else if (flag_q && code == CC_ESC) esc_q <= 1'b1;
            end
          end
        endcase
      end
    end
  end

  // error terms the state machine acts on
  assign fault     = disc_err | ev.par_err | ev.esc_err;
  assign seq_err   = (ev.fct && (st_q == settle_wait_state || st_q == ready_state || st_q == null_tx_state))
                   || (ev.nchar && st_q != operational_state);
  assign cred_err  = ev.nchar && st_q == operational_state && rx_cred_q == '0;
  assign empty_err = ev.mark && st_q == operational_state && last_mark_q;
  assign link_en   = !ctrl_q.dis && (ctrl_q.start || (ctrl_q.auto_c && null_seen_q));

  always_comb begin
    unique case (st_q)
      hold_reset_state: timed_out = tmr_q == TMR_W'(RESET_CYC - 1);
      default:          timed_out = tmr_q == TMR_W'(WAIT_CYC - 1);
    endcase
  end

  // state transitions
  always_comb begin
    st_d = st_q;
    unique case (st_q)
      hold_reset_state:  if (timed_out) st_d = settle_wait_state;
      settle_wait_state: begin
        if (fault || ev.fct || ev.nchar) st_d = hold_reset_state;
        else if (timed_out) st_d = ready_state;
      end
      ready_state: begin
        if (fault || ev.fct || ev.nchar) st_d = hold_reset_state;
        else if (link_en) st_d = null_tx_state;
      end
      null_tx_state: begin
        if (fault || seq_err) st_d = hold_reset_state;
        else if (null_seen_q && null_sent_q) st_d = handshake_state;
        else if (timed_out) st_d = hold_reset_state;
      end
      handshake_state: begin
        if (fault || seq_err) st_d = hold_reset_state;
        else if (ev.fct) st_d = operational_state;
        else if (timed_out) st_d = hold_reset_state;
      end
      operational_state: begin
        if (fault || cred_err || empty_err || ctrl_q.dis) st_d = hold_reset_state;
      end
      default: st_d = hold_reset_state;
    endcase
  end

  // state register; any reset source lands in hold-reset
  always_ff @(posedge clk) begin
    if (rst || srst_q) st_q <= hold_reset_state;
    else st_q <= st_d;
  end

  // interval timer restarts on every state change
  always_ff @(posedge clk) begin
    if (rst || srst_q || st_d != st_q) tmr_q <= '0;
    else if (!timed_out) tmr_q <= tmr_q + 1'b1;
  end

  // credits: what we granted the peer, and what the peer granted us
  always_ff @(posedge clk) begin
    if (rst || !(st_q == handshake_state || st_q == operational_state)) begin
      rx_cred_q   <= '0;
      tx_cred_q   <= '0;
      last_mark_q <= 1'b0;
    end else begin
      rx_cred_q <= rx_cred_q + ((slot && fct_want) ? CW'(CRED_STEP) : CW'(0))
                 - ((ev.nchar && rx_cred_q != '0) ? CW'(1) : CW'(0));
      tx_cred_q <= tx_cred_q + ((ev.fct && tx_cred_q <= CW'(CRED_MAX - CRED_STEP)) ? CW'(CRED_STEP) : CW'(0))
                 - (tx_take ? CW'(1) : CW'(0));
      if (ev.nchar) last_mark_q <= ev.mark;
    end
  end

  // received characters to the host, operational state only
  always_ff @(posedge clk) begin
    if (rst) begin
      rx_valid <= 1'b0;
      rx_data  <= '0;
    end else begin
      rx_valid <= ev.nchar && st_q == operational_state && !cred_err && !empty_err;
      if (ev.nchar) rx_data <= ev.mark ? {1'b1, 7'h00, code == CC_EEP} : {1'b0, dat_nx};
    end
  end

  // bit-rate divider
  always_ff @(posedge clk) begin
    if (rst || div_q == DW'(TX_DIV - 1)) div_q <= '0;
    else div_q <= div_q + 1'b1;
  end

  assign tick     = div_q == DW'(TX_DIV - 1);
  assign tx_on    = st_q == null_tx_state || st_q == handshake_state || st_q == operational_state;
  assign fct_want = (st_q == handshake_state || st_q == operational_state)
                  && rx_cred_q <= CW'(CRED_MAX - CRED_STEP);
  assign slot     = tick && tx_on && tcnt_q == '0;
  assign tx_ready = slot && st_q == operational_state && !fct_want && tx_cred_q != '0;
  assign tx_take  = tx_ready && tx_valid;

  // next character: FCT first, then host data, otherwise a NULL to keep the line alive
  always_comb begin
    esc_c = lie_char(tpar_q, 1'b1, {6'h00, CC_ESC});
    fct_c = lie_char(esc_c.par, 1'b1, {6'h00, CC_FCT});
    dat_c = tx_data[8] ? lie_char(tpar_q, 1'b1, {6'h00, tx_data[0] ? CC_EEP : CC_EOP})
                       : lie_char(tpar_q, 1'b0, tx_data[7:0]);
    if (fct_want) nx = lie_char(tpar_q, 1'b1, {6'h00, CC_FCT});
    else if (tx_take) nx = dat_c;
    else nx = '{len: LEN_NULL, par: fct_c.par, bits: {4'h0, fct_c.bits[3:0], esc_c.bits[3:0]}};
    tbits = (tcnt_q == '0) ? nx.bits : tsh_q;
  end

  // data-strobe serializer; strobe toggles whenever data repeats
  always_ff @(posedge clk) begin
    if (rst) begin
      tsh_q    <= '0;
      tcnt_q   <= '0;
      tpar_q   <= 1'b0;
      data_out   <= 1'b0;
      strobe_out <= 1'b0;
    end else if (tick) begin
      if (tx_on) begin
        data_out   <= tbits[0];
        strobe_out <= strobe_out ^ ~(tbits[0] ^ data_out);
        tsh_q      <= tbits >> 1;
        tcnt_q     <= ((tcnt_q == '0) ? nx.len : tcnt_q) - 1'b1;
        if (tcnt_q == '0) tpar_q <= nx.par;
      end else begin
        // stop first, then strobe, then data, one per bit period so both never move together
        tsh_q  <= '0;
        tcnt_q <= '0;
        tpar_q <= 1'b0;
        if (strobe_out) strobe_out <= 1'b0;
        else data_out <= 1'b0;
      end
    end
  end

  // at least one NULL must have gone out before the handshake starts
  always_ff @(posedge clk) begin
    if (rst || st_q != null_tx_state) null_sent_q <= 1'b0;
    else if (slot) null_sent_q <= 1'b1;
  end

  assign link_run  = st_q == operational_state;
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign ap        = hsel && hready && htrans[1];

  // register read mux; unmapped addresses read as zero
  function automatic logic [31:0] rd_mux(input logic [7:0] a);
    unique case (a)
      A_CTRL:  rd_mux = 32'({1'b0, ctrl_q.dis, ctrl_q.auto_c, ctrl_q.start});
      A_STAT:  rd_mux = 32'({null_seen_q, 2'h0, st_q});
      A_ERR:   rd_mux = 32'(err_q);
      A_CRED:  rd_mux = 32'({tx_cred_q, (CRED_TX_LSB - CW)'(0), rx_cred_q});
      default: rd_mux = 32'h0000_0000;
    endcase
  endfunction : rd_mux

  // address phase capture; read data is latched so it stands through the data phase
  always_ff @(posedge clk) begin
    if (rst) begin
      wr_q   <= 1'b0;
      ad_q   <= '0;
      hrdata <= '0;
    end else if (hready) begin
      wr_q   <= ap && hwrite;
      ad_q   <= haddr[ADDR_W-1:0];
      hrdata <= (ap && !hwrite) ? rd_mux(haddr[ADDR_W-1:0]) : 32'h0000_0000;
    end
  end

  // control register; soft reset is a one-cycle pulse that never stays set
  always_ff @(posedge clk) begin
    if (rst) begin
      ctrl_q <= '0;
      srst_q <= 1'b0;
    end else begin
      srst_q <= wr_q && ad_q == A_CTRL && hwdata[CTRL_W-1];
      if (wr_q && ad_q == A_CTRL) ctrl_q <= lie_ctrl_t'({1'b0, hwdata[CTRL_W-2:0]});
    end
  end

  assign err_set[E_DISC]  = disc_err;
  assign err_set[E_PAR]   = ev.par_err;
  assign err_set[E_ESC]   = ev.esc_err;
  assign err_set[E_SEQ]   = seq_err;
  assign err_set[E_CRED]  = cred_err;
  assign err_set[E_EMPTY] = empty_err;

  // sticky error bits, write one to clear; a new error in the clearing cycle wins
  for (genvar g = 0; g < N_ERR; g++) begin : g_err
    always_ff @(posedge clk) begin
      if (rst) err_q[g] <= 1'b0;
      else if (err_set[g]) err_q[g] <= 1'b1;
      else if (wr_q && ad_q == A_ERR && hwdata[g]) err_q[g] <= 1'b0;
    end
  end

endmodule : lie_link_fsm

// File: lie_link_fsm_asserts.sv
// lie_link_fsm_asserts.sv: port checker of the link state machine and its bind
`timescale 1ns/1ns
module lie_link_fsm_asserts #(
  parameter int unsigned RESET_CYC = 640,
  parameter int unsigned WAIT_CYC  = 1280,
  parameter int unsigned DISC_CYC  = 85,
  parameter int unsigned TX_DIV    = 16
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // link pins and status
  input wire logic data_in,
  input wire logic strobe_in,
  input wire logic data_out,
  input wire logic strobe_out,
  input wire logic rx_valid,
  input wire logic tx_ready,
  input wire logic link_run
);
  logic [15:0] cyc_q;
  logic [15:0] gap_q;
  logic [15:0] idle_q;
  logic [3:0]  pins_q;
  logic        tx_edge;
  logic        rx_edge;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);
  assign tx_edge = {data_out, strobe_out} != pins_q[1:0];
  assign rx_edge = {data_in, strobe_in} != pins_q[3:2];
  // pin levels one cycle back
  always_ff @(posedge clk) begin
    pins_q <= {data_in, strobe_in, data_out, strobe_out};
  end
  // cycles since reset; saturates so a long run never wraps
  always_ff @(posedge clk) begin
    if (rst)
      cyc_q <= '0;
    else if (cyc_q != '1)
      cyc_q <= cyc_q + 16'h1;
  end
  // cycles since the last output edge; reset counts as a full gap
  always_ff @(posedge clk) begin
    if (rst)
      gap_q <= 16'(TX_DIV);
    else if (tx_edge)
      gap_q <= 16'h1;
    else if (gap_q != '1)
      gap_q <= gap_q + 16'h1;
  end
  // cycles since the last input edge
  always_ff @(posedge clk) begin
    if (rst || rx_edge)
      idle_q <= '0;
    else if (idle_q != '1)
      idle_q <= idle_q + 16'h1;
  end
  sequence s_quiet;
    !link_run && !data_out && !strobe_out;
  endsequence
  a_reset_quiet: assert property ($fell(rst) |-> s_quiet)
    else $error("link active after reset");
  a_ds_order: assert property (!(data_out != pins_q[1] && strobe_out != pins_q[0]))
    else $error("data and strobe moved together");
  a_rx_in_run: assert property (rx_valid |-> $past(link_run))
    else $error("character delivered outside run");
  a_tx_in_run: assert property (tx_ready |-> link_run)
    else $error("transmit accepted outside run");
  a_hold_time: assert property (link_run |-> cyc_q >= RESET_CYC + WAIT_CYC)
    else $error("run reached before reset and settle time");
  a_idle_tx: assert property (cyc_q < RESET_CYC + WAIT_CYC |-> !data_out && !strobe_out)
    else $error("transmitter active in reset or settle");
  a_tx_gap: assert property (tx_edge |-> gap_q >= TX_DIV)
    else $error("output bits closer than one bit time");
  a_disc_bound: assert property (idle_q > DISC_CYC + 10 |-> !link_run)
    else $error("silent link still running");
endmodule : lie_link_fsm_asserts

bind lie_link_fsm lie_link_fsm_asserts #(
  .RESET_CYC(RESET_CYC), .WAIT_CYC(WAIT_CYC), .DISC_CYC(DISC_CYC), .TX_DIV(TX_DIV)
) u_chk (.clk(clk), .rst(rst), .data_in(data_in), .strobe_in(strobe_in), .data_out(data_out),
  .strobe_out(strobe_out), .rx_valid(rx_valid), .tx_ready(tx_ready), .link_run(link_run));

// File: lie_peer.sv
// lie_peer.sv: behavioural far-end link interface sending queued characters
`timescale 1ns/1ns
module lie_peer (
  // link lines toward the block
  output logic d,
  output logic s
);
  // queue: bit 9 control, bit 8 forces bad parity, bits 7:0 value or code
  logic [9:0] q[$];
  logic       alive;
  logic       prv;
  // one bit per 160 ns; strobe moves only when data repeats
  task automatic bit_out(input logic b);
    if (b == d)
      s = ~s;
    else
      d = b;
    #160;
  endtask : bit_out
  // odd parity over last payload, own flag and itself
  task automatic chr(input logic [9:0] c);
    bit_out(~(prv ^ c[9]) ^ c[8]);
    bit_out(c[9]);
    if (c[9]) begin
      bit_out(c[1]);
      bit_out(c[0]);
      prv = c[1] ^ c[0];
    end else begin
      for (int i = 0; i < 8; i++)
        bit_out(c[i]);
      prv = ^c[7:0];
    end
  endtask : chr
  // queued chars first, NULLs while alive, else lines stand still
  initial begin
    {d, s, prv, alive} = 4'h0;
    #3;
    forever begin
      if (q.size() > 0)
        chr(q.pop_front());
      else if (alive) begin
        chr(10'h203);
        chr(10'h200);
      end else
        #160;
    end
  end
endmodule : lie_peer

// File: lie_link_fsm_tb_top.sv
// lie_link_fsm_tb_top.sv: register-driven bring-up and error scenarios
`timescale 1ns/1ns
module lie_link_fsm_tb_top;
  import lie_pkg::*;
  localparam int RC = 100;
  localparam int WC = 500;
  localparam int DLY [4] = '{RC - 10, 12, WC - 20, 12};
  localparam logic [31:0] EXP [4] = '{32'h1, 32'h2, 32'h2, 32'h4};
  localparam logic [31:0] ERRM [4] = '{32'h20, 32'h2, 32'h4, 32'h1};
  logic        clk, rst, hsel, hwrite, hreadyout, hresp, tx_valid, tx_ready;
  logic        data_in, strobe_in, data_out, strobe_out, rx_valid, link_run;
  logic [31:0] haddr, hwdata, hrdata, v;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [8:0]  tx_data, rx_data;
  logic [8:0]  rx_q[$];
  int          n_fail, checked, n;

  // 100 MHz system clock
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  lie_link_fsm #(.RESET_CYC(RC), .WAIT_CYC(WC)) dut (
    .clk(clk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hrdata(hrdata),
    .hresp(hresp), .data_in(data_in), .strobe_in(strobe_in), .data_out(data_out),
    .strobe_out(strobe_out), .tx_valid(tx_valid), .tx_data(tx_data), .tx_ready(tx_ready),
    .rx_valid(rx_valid), .rx_data(rx_data), .link_run(link_run));
  lie_peer peer (.d(data_in), .s(strobe_in));

  // delivered characters in arrival order
  always @(posedge clk)
    if (rx_valid === 1'b1)
      rx_q.push_back(rx_data);

  task automatic conclude;
    $display("checked %0d mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : conclude

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // one single transfer: address phase, then data phase, each held until hready
  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd);
    hsel   <= 1'b1;
    htrans <= 2'h2;
    haddr  <= {24'h0, a};
    hwrite <= w;
    @(posedge clk);
    while (hreadyout !== 1'b1)
      @(posedge clk);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    @(posedge clk);
    while (hreadyout !== 1'b1)
      @(posedge clk);
    rd = hrdata;
  endtask : ahb

  task automatic wr(input logic [7:0] a, input logic [31:0] wd);
    logic [31:0] x;
    ahb(1'b1, a, wd, x);
  endtask : wr

  task automatic rd(input logic [7:0] a);
    ahb(1'b0, a, 32'h0, v);
  endtask : rd

  // poll the state field, bounded, so a stuck machine still ends the run
  task automatic wait_st(input logic [5:0] st);
    rd(A_STAT);
    for (int i = 0; i < 3000 && v[5:0] !== st; i++)
      rd(A_STAT);
    chk({26'h0, v[5:0]}, {26'h0, st});
  endtask : wait_st

  // auto-connect bring-up: peer NULLs, one FCT only once handshake shows
  task automatic up;
    wait_st(6'h10);
    peer.q.push_back(10'h200);
    for (n = 0; n < 3000 && link_run !== 1'b1; n++)
      @(posedge clk);
    rd(A_STAT);
    chk(v, 32'h120);
  endtask : up

  // cut a hang short
  initial begin
    #400000;
    n_fail++;
    conclude();
  end

  initial begin
    {rst, hsel, hwrite, tx_valid} = 4'h8;
    {haddr, hwdata, htrans, tx_data} = '0;
    hsize = 3'h2;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    rd(A_STAT);
    chk(v, 32'h1);
    rd(8'h10);
    chk(v, 32'h0);
    chk({31'h0, hresp}, 32'h0);
    // sample just before and after each timed step
    for (int i = 0; i < 4; i++) begin
      repeat (DLY[i]) @(posedge clk);
      rd(A_STAT);
      chk(v, EXP[i]);
    end
    wr(A_CTRL, 32'h5);
    repeat (50) @(posedge clk);
    rd(A_STAT);
    chk(v, 32'h4);
    wr(A_CTRL, 32'h2);
    peer.alive = 1'b1;
    // each pass: run, inject one fault, expect the drop and its flag
    for (int k = 0; k < 4; k++) begin
      up();
      case (k)
        0: peer.q = '{10'h0a5, 10'h201, 10'h201};
        1: peer.q.push_back(10'h15a);
        2: peer.q = '{10'h203, 10'h201};
        default: peer.alive = 1'b0;
      endcase
      for (n = 0; n < 5000 && link_run === 1'b1; n++)
        @(posedge clk);
      rd(A_ERR);
      chk(v & ERRM[k], ERRM[k]);
      peer.alive = 1'b1;
      wr(A_ERR, 32'h3f);
    end
    chk(32'(rx_q.size()), 32'h2);
    chk({23'h0, rx_q[0]}, 32'h0a5);
    chk({23'h0, rx_q[1]}, 32'h100);
    up();
    // the one FCT that opened the run grants eight characters of transmit credit
    rd(A_CRED);
    chk(v & 32'h3f00, 32'h0800);
    wr(A_CTRL, 32'h6);
    wait_st(6'h04);
    repeat (200) @(posedge clk);
    rd(A_STAT);
    chk(v, 32'h104);
    peer.q.push_back(10'h200);
    wait_st(6'h01);
    rd(A_ERR);
    chk(v & 32'h8, 32'h8);
    wait_st(6'h02);
    wr(A_CTRL, 32'hc);
    repeat (2) @(posedge clk);
    rd(A_STAT);
    chk(v & 32'h3f, 32'h1);
    conclude();
  end
endmodule : lie_link_fsm_tb_top
